/* sim/tb_rotate_mask_unit.sv */
// Purpose: Self-checking bench for the registered rotate-and-mask stage
// Assumes: Result and strobes one cycle after a taken request
// Notes:   Inputs change on the falling edge, outputs read there too
module tb_rotate_mask_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             opValid = 1'b0;
  rmu_pkg::rmu_op_e opSel = rmu_pkg::RMU_OP_AND_IMM;
  logic             recordEn = 1'b0;
  logic             summaryOverflow = 1'b0;
  logic [31:0]      sourceReg = 32'h0, amountReg = 32'h0, destRegIn = 32'h0;
  logic [4:0]       shiftAmountImm = 5'h0, maskBegin = 5'h0, maskEnd = 5'h0;
  logic [3:0]       condFieldZeroIn = 4'h0, condFieldZeroOut;
  logic [31:0]      destRegOut;
  logic             destWe, condFieldZeroWe;
  int               error_cnt = 0;
  int               compares = 0;

  always #2.5 clk = ~clk;

  rmu_top i_dut (.clk(clk), .rst_n(rst_n), .opValid(opValid), .opSel(opSel),
    .recordEn(recordEn), .sourceReg(sourceReg), .amountReg(amountReg),
    .destRegIn(destRegIn), .shiftAmountImm(shiftAmountImm), .maskBegin(maskBegin),
    .maskEnd(maskEnd), .summaryOverflow(summaryOverflow),
    .condFieldZeroIn(condFieldZeroIn), .destRegOut(destRegOut), .destWe(destWe),
    .condFieldZeroOut(condFieldZeroOut), .condFieldZeroWe(condFieldZeroWe));

  // Position 0 is the most significant bit
  function automatic logic [31:0] mk(input logic [4:0] b, input logic [4:0] e);
    logic [31:0] m;
    for (int p = 0; p < 32; p++) m[31-p] = (b <= e) ? (p >= b && p <= e) : (p >= b || p <= e);
    return m;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic op(input rmu_pkg::rmu_op_e s, input logic rec, input logic [31:0] src,
                    input logic [31:0] amt, input logic [31:0] dst, input logic [4:0] sh,
                    input logic [4:0] mb, input logic [4:0] me, input logic so,
                    input logic [31:0] res);
    logic [3:0] cr;
    cr = rec ? {res[31], !res[31] && res != 32'h0, res == 32'h0, so} : 4'h6;
    opValid = 1'b1; opSel = s; recordEn = rec; sourceReg = src; amountReg = amt;
    destRegIn = dst; shiftAmountImm = sh; maskBegin = mb; maskEnd = me;
    summaryOverflow = so; condFieldZeroIn = 4'h6;
    @(negedge clk);
    chk(32'(destWe), 32'h1);
    chk(destRegOut, res);
    chk(32'(condFieldZeroWe), 32'(rec));
    chk(32'(condFieldZeroOut), 32'(cr));
  endtask

  task automatic t_walk;
    op(rmu_pkg::RMU_OP_AND_IMM, 1'b0, 32'h1234_5678, 32'h9, 32'hffff_ffff, 5'h10, 5'h10,
       5'h17, 1'b0, 32'h0000_1200);
  endtask

  task automatic t_masks;
    logic [4:0] bt [8] = '{5'h0, 5'h10, 5'h1f, 5'h5, 5'h1f, 5'h0, 5'h14, 5'h7};
    logic [4:0] et [8] = '{5'h1f, 5'h17, 5'h1f, 5'h5, 5'h0, 5'h0, 5'h3, 5'h6};
    for (int i = 0; i < 8; i++) begin
      op(rmu_pkg::RMU_OP_INSERT, 1'b0, 32'hffff_ffff, 32'h7, 32'h0, 5'h0, bt[i], et[i],
         1'b0, mk(bt[i], et[i]));
      chk(32'(destRegOut == 32'h0), 32'h0);
    end
  endtask

  task automatic t_amount;
    op(rmu_pkg::RMU_OP_AND_REG, 1'b0, 32'h8000_0001, 32'hffff_ffe3, 32'h0, 5'h9, 5'h0,
       5'h1f, 1'b0, 32'h0000_000c);
    for (int n = 0; n < 32; n++) begin
      op(rmu_pkg::RMU_OP_AND_REG, 1'b0, 32'h1, {27'h2aa_aaaa, 5'(n)}, 32'h0, 5'h0, 5'h0,
         5'h1f, 1'b0, 32'h1 << n);
    end
  endtask

  task automatic t_insert;
    op(rmu_pkg::RMU_OP_INSERT, 1'b1, 32'h1234_5678, 32'h4, 32'haaaa_aaaa, 5'h10, 5'h10,
       5'h17, 1'b1, 32'haaaa_12aa);
    op(rmu_pkg::RMU_OP_INSERT, 1'b1, 32'h0f00_0000, 32'h0, 32'h0, 5'h8, 5'h18, 5'h1f, 1'b0,
       32'h0000_000f);
  endtask

  task automatic t_record;
    op(rmu_pkg::RMU_OP_AND_IMM, 1'b1, 32'h0, 32'h0, 32'h0, 5'h3, 5'h0, 5'h1f, 1'b1,
       32'h0);
    op(rmu_pkg::RMU_OP_AND_REG, 1'b1, 32'h0000_0001, 32'h1f, 32'h0, 5'h0, 5'h0, 5'h1f, 1'b0,
       32'h8000_0000);
  endtask

  task automatic t_refuse;
    opValid = 1'b1;
    opSel = rmu_pkg::rmu_op_e'(3'b011);
    sourceReg = 32'h5555_5555;
    @(negedge clk);
    opValid = 1'b0;
    chk(32'({destWe, condFieldZeroWe}), 32'h0);
    chk(destRegOut, 32'h8000_0000);
  endtask

  // Drops the strobe for one cycle; nothing may be written
  task automatic idle;
    opValid = 1'b0;
    @(negedge clk);
    chk(32'({destWe, condFieldZeroWe}), 32'h0);
  endtask

  // Mid-run reset clears every output and keeps it clear after release
  task automatic t_reset;
    rst_n = 1'b0;
    @(negedge clk);
    chk(destRegOut, 32'h0);
    chk(32'({condFieldZeroOut, destWe, condFieldZeroWe}), 32'h0);
    rst_n = 1'b1;
    @(negedge clk);
    chk(destRegOut, 32'h0);
    chk(32'({condFieldZeroOut, destWe, condFieldZeroWe}), 32'h0);
  endtask

  task automatic complete_run;
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge clk);
    chk({destRegOut[31:2], destWe, condFieldZeroWe}, 32'h0);
    chk(32'(condFieldZeroOut), 32'h0);
    rst_n = 1'b1;
    @(negedge clk);
    t_walk();
    idle();
    t_masks();
    idle();
    t_amount();
    idle();
    t_insert();
    idle();
    t_record();
    idle();
    t_refuse();
    t_reset();
    complete_run();
  end

  // Watchdog against a hung run
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule

/* verilog/rmu_mask_gen.sv */
// Purpose: Wrap-around mask from begin and end positions
// Assumes: Position 0 is the most significant bit
// Notes:   Pure combinational
module rmu_mask_gen #(
  parameter int unsigned WIDTH = rmu_pkg::WORD_W,
  parameter int unsigned FW    = rmu_pkg::FIELD_W
) (
  input  wire logic [FW-1:0]    maskBegin,
  input  wire logic [FW-1:0]    maskEnd,
  output logic      [WIDTH-1:0] mask
);
  // Position p in MSB-first numbering maps to vector bit WIDTH-1-p
  always_comb begin
    for (int p = 0; p < WIDTH; p++) begin
      if (maskBegin <= maskEnd) begin
        mask[WIDTH-1-p] = (FW'(p) >= maskBegin) && (FW'(p) <= maskEnd);
      end else begin
        mask[WIDTH-1-p] = (FW'(p) >= maskBegin) || (FW'(p) <= maskEnd);
      end
    end
  end
endmodule

/* verilog/rmu_pkg.sv */
// Purpose: Shared constants and types for the rotate-and-mask unit
// Assumes: 32-bit word, bit 0 is the most significant bit in field numbering
// Notes:   Condition field layout is {lt, gt, eq, so}
package rmu_pkg;
  localparam int unsigned WORD_W  = 32;
  localparam int unsigned FIELD_W = 5;
  localparam int unsigned CR_W    = 4;
  localparam int unsigned CR_LT   = 3;
  localparam int unsigned CR_GT   = 2;
  localparam int unsigned CR_EQ   = 1;
  localparam int unsigned CR_SO   = 0;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [3:0]  CR_RST   = 4'h0;

  typedef enum logic [2:0] {
    RMU_OP_AND_IMM = 3'b001,
    RMU_OP_AND_REG = 3'b010,
    RMU_OP_INSERT  = 3'b100
  } rmu_op_e;
endpackage

/* verilog/rmu_rotator.sv */
// Purpose: Left rotate toward the most significant bit
// Assumes: Count in range 0 to WIDTH-1
// Notes:   Pure combinational
module rmu_rotator #(
  parameter int unsigned WIDTH = rmu_pkg::WORD_W,
  parameter int unsigned CW    = rmu_pkg::FIELD_W
) (
  input  wire logic [WIDTH-1:0] dataIn,
  input  wire logic [CW-1:0]    count,
  output logic      [WIDTH-1:0] dataOut
);
  logic [2*WIDTH-1:0] doubled;
  always_comb begin
    doubled = {dataIn, dataIn} << count;
    dataOut = doubled[2*WIDTH-1:WIDTH];
  end
endmodule

/* verilog/rmu_top.sv */
// Purpose: Registered rotate-then-mask and rotate-then-insert stage
// Assumes: Operands arrive valid with opValid for one cycle
// Notes:   Result and condition field appear one cycle after the request
module rmu_top #(
  parameter int unsigned WIDTH = rmu_pkg::WORD_W,
  parameter int unsigned FW    = rmu_pkg::FIELD_W
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   opValid,
  input  wire rmu_pkg::rmu_op_e       opSel,
  input  wire logic                   recordEn,
  input  wire logic [WIDTH-1:0]       sourceReg,
  input  wire logic [WIDTH-1:0]       amountReg,
  input  wire logic [WIDTH-1:0]       destRegIn,
  input  wire logic [FW-1:0]          shiftAmountImm,
  input  wire logic [FW-1:0]          maskBegin,
  input  wire logic [FW-1:0]          maskEnd,
  input  wire logic                   summaryOverflow,
  input  wire logic [rmu_pkg::CR_W-1:0] condFieldZeroIn,
  output logic      [WIDTH-1:0]       destRegOut,
  output logic                        destWe,
  output logic      [rmu_pkg::CR_W-1:0] condFieldZeroOut,
  output logic                        condFieldZeroWe
);
  typedef struct packed {
    logic [WIDTH-1:0]          result;
    logic                      we;
    logic [rmu_pkg::CR_W-1:0]  cr;
    logic                      crWe;
  } rmu_state_s;

  rmu_state_s st_r;
  rmu_state_s st_nxt;

  logic [FW-1:0]    rotCount;
  logic [WIDTH-1:0] rotated;
  logic [WIDTH-1:0] mask;
  logic [WIDTH-1:0] merged;
  logic             legalOp;

  function automatic logic [rmu_pkg::CR_W-1:0] crFromResult(
    input logic [WIDTH-1:0] r,
    input logic             so
  );
    logic [rmu_pkg::CR_W-1:0] c;
    c = rmu_pkg::CR_RST;
    c[rmu_pkg::CR_LT] = r[WIDTH-1];
    c[rmu_pkg::CR_GT] = !r[WIDTH-1] && (r != '0);
    c[rmu_pkg::CR_EQ] = (r == '0);
    c[rmu_pkg::CR_SO] = so;
    return c;
  endfunction

  always_comb begin
    // Register count uses only the low bits; insert never uses the register
    rotCount = (opSel == rmu_pkg::RMU_OP_AND_REG) ? amountReg[FW-1:0]
                                                  : shiftAmountImm;
  end

  rmu_rotator #(.WIDTH(WIDTH), .CW(FW)) uRot (
    .dataIn  (sourceReg),
    .count   (rotCount),
    .dataOut (rotated)
  );

  rmu_mask_gen #(.WIDTH(WIDTH), .FW(FW)) uMask (
    .maskBegin (maskBegin),
    .maskEnd   (maskEnd),
    .mask      (mask)
  );

  always_comb begin
    legalOp = (opSel == rmu_pkg::RMU_OP_AND_IMM) || (opSel == rmu_pkg::RMU_OP_AND_REG)
           || (opSel == rmu_pkg::RMU_OP_INSERT);
    if (opSel == rmu_pkg::RMU_OP_INSERT) begin
      merged = (rotated & mask) | (destRegIn & ~mask);
    end else begin
      merged = rotated & mask;
    end
  end

  always_comb begin
    st_nxt      = st_r;
    st_nxt.we   = 1'b0;
    st_nxt.crWe = 1'b0;
    if (opValid && legalOp) begin
      st_nxt.result = merged;
      st_nxt.we     = 1'b1;
      if (recordEn) begin
        st_nxt.cr   = crFromResult(merged, summaryOverflow);
        st_nxt.crWe = 1'b1;
      end else begin
        st_nxt.cr   = condFieldZeroIn;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{result: rmu_pkg::WORD_RST, we: 1'b0, cr: rmu_pkg::CR_RST, crWe: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // No exception-register port exists, so it cannot be touched
  assign destRegOut       = st_r.result;
  assign destWe           = st_r.we;
  assign condFieldZeroOut = st_r.cr;
  assign condFieldZeroWe  = st_r.crWe;

  property p_mask_nonzero;
    @(posedge clk) disable iff (!rst_n) mask != '0;
  endproperty
  a_mask_nonzero: assert property (p_mask_nonzero) else $error("mask all zero");

  property p_mask_begin_set;
    @(posedge clk) disable iff (!rst_n) mask[WIDTH-1-maskBegin] && mask[WIDTH-1-maskEnd];
  endproperty
  a_mask_begin_set: assert property (p_mask_begin_set) else $error("mask ends clear");

  property p_and_result;
    @(posedge clk) disable iff (!rst_n)
      (opValid && opSel != rmu_pkg::RMU_OP_INSERT && legalOp) |=>
        destWe && destRegOut == ($past(rotated) & $past(mask));
  endproperty
  a_and_result: assert property (p_and_result) else $error("and result wrong");

  property p_insert_keep;
    @(posedge clk) disable iff (!rst_n)
      (opValid && opSel == rmu_pkg::RMU_OP_INSERT) |=>
        (destRegOut & ~$past(mask)) == ($past(destRegIn) & ~$past(mask));
  endproperty
  a_insert_keep: assert property (p_insert_keep) else $error("insert lost bits");

  property p_rotate_msb_wrap;
    @(posedge clk) disable iff (!rst_n)
      (rotCount == FW'(1)) |-> rotated == {sourceReg[WIDTH-2:0], sourceReg[WIDTH-1]};
  endproperty
  a_rotate_msb_wrap: assert property (p_rotate_msb_wrap) else $error("rotate wrong");

  property p_reg_count;
    @(posedge clk) disable iff (!rst_n)
      (opSel == rmu_pkg::RMU_OP_AND_REG) |-> rotCount == amountReg[FW-1:0];
  endproperty
  a_reg_count: assert property (p_reg_count) else $error("reg count wrong");

  property p_imm_count;
    @(posedge clk) disable iff (!rst_n)
      (opSel != rmu_pkg::RMU_OP_AND_REG) |-> rotCount == shiftAmountImm;
  endproperty
  a_imm_count: assert property (p_imm_count) else $error("imm count wrong");

  sequence s_plain_op;
    opValid && legalOp && !recordEn;
  endsequence
  property p_no_record;
    @(posedge clk) disable iff (!rst_n) s_plain_op |=> !condFieldZeroWe;
  endproperty
  a_no_record: assert property (p_no_record) else $error("cr written");

  property p_record_eq;
    @(posedge clk) disable iff (!rst_n)
      (opValid && legalOp && recordEn) |=> condFieldZeroWe
        && condFieldZeroOut[rmu_pkg::CR_EQ] == (destRegOut == '0)
        && condFieldZeroOut[rmu_pkg::CR_LT] == destRegOut[WIDTH-1]
        && condFieldZeroOut[rmu_pkg::CR_SO] == $past(summaryOverflow);
  endproperty
  a_record_eq: assert property (p_record_eq) else $error("cr value wrong");

  // Mask rebuilt from two shifted spans, independent of the generator loop
  function automatic logic [WIDTH-1:0] spanMask(
    input logic [FW-1:0] b,
    input logic [FW-1:0] e
  );
    logic [WIDTH-1:0] fromBegin;
    logic [WIDTH-1:0] toEnd;
    fromBegin = {WIDTH{1'b1}} >> b;
    toEnd     = {WIDTH{1'b1}} << (WIDTH - 1 - e);
    return (b <= e) ? (fromBegin & toEnd) : (fromBegin | toEnd);
  endfunction

  // Accepted request, its flavours and the refused case
  sequence s_take;
    opValid && legalOp;
  endsequence

  sequence s_take_and;
    opValid && legalOp && (opSel != rmu_pkg::RMU_OP_INSERT);
  endsequence

  sequence s_take_insert;
    opValid && (opSel == rmu_pkg::RMU_OP_INSERT);
  endsequence

  sequence s_take_record;
    opValid && legalOp && recordEn;
  endsequence

  sequence s_refused;
    !(opValid && legalOp);
  endsequence

  property p_mask_order;
    @(posedge clk) disable iff (!rst_n)
      (maskBegin <= maskEnd) |-> mask == spanMask(maskBegin, maskEnd);
  endproperty
  a_mask_order: assert property (p_mask_order) else $error("plain mask wrong");

  property p_mask_wrap;
    @(posedge clk) disable iff (!rst_n)
      (maskBegin > maskEnd) |-> mask == spanMask(maskBegin, maskEnd);
  endproperty
  a_mask_wrap: assert property (p_mask_wrap) else $error("wrapped mask wrong");

  property p_mask_count;
    @(posedge clk) disable iff (!rst_n)
      $countones(mask) == ((maskBegin <= maskEnd) ? (int'(maskEnd) - int'(maskBegin) + 1)
        : (int'(WIDTH) - int'(maskBegin) + int'(maskEnd) + 1));
  endproperty
  a_mask_count: assert property (p_mask_count) else $error("mask count wrong");

  property p_rotate_ref;
    @(posedge clk) disable iff (!rst_n)
      rotated == ((sourceReg << rotCount) | (sourceReg >> (WIDTH - rotCount)));
  endproperty
  a_rotate_ref: assert property (p_rotate_ref) else $error("rotate value wrong");

  property p_insert_imm;
    @(posedge clk) disable iff (!rst_n)
      (opSel == rmu_pkg::RMU_OP_INSERT) |-> rotCount == shiftAmountImm;
  endproperty
  a_insert_imm: assert property (p_insert_imm) else $error("insert count wrong");

  property p_take_we;
    @(posedge clk) disable iff (!rst_n)
      s_take |=> destWe;
  endproperty
  a_take_we: assert property (p_take_we) else $error("write strobe missing");

  property p_we_source;
    @(posedge clk) disable iff (!rst_n)
      destWe |-> $past(opValid && legalOp);
  endproperty
  a_we_source: assert property (p_we_source) else $error("stray write strobe");

  property p_and_clear;
    @(posedge clk) disable iff (!rst_n)
      s_take_and |=> (destRegOut & ~$past(mask)) == '0;
  endproperty
  a_and_clear: assert property (p_and_clear) else $error("and left bits set");

  property p_insert_set;
    @(posedge clk) disable iff (!rst_n)
      s_take_insert |=> (destRegOut & $past(mask)) == ($past(rotated) & $past(mask));
  endproperty
  a_insert_set: assert property (p_insert_set) else $error("insert bits wrong");

  property p_refuse_quiet;
    @(posedge clk) disable iff (!rst_n)
      s_refused |=> !destWe && !condFieldZeroWe;
  endproperty
  a_refuse_quiet: assert property (p_refuse_quiet) else $error("strobe on refusal");

  property p_refuse_hold;
    @(posedge clk) disable iff (!rst_n)
      s_refused |=> $stable(destRegOut) && $stable(condFieldZeroOut);
  endproperty
  a_refuse_hold: assert property (p_refuse_hold) else $error("outputs moved idle");

  property p_plain_keep_cr;
    @(posedge clk) disable iff (!rst_n)
      s_plain_op |=> condFieldZeroOut == $past(condFieldZeroIn);
  endproperty
  a_plain_keep_cr: assert property (p_plain_keep_cr) else $error("cr not kept");

  property p_record_we;
    @(posedge clk) disable iff (!rst_n)
      s_take_record |=> condFieldZeroWe;
  endproperty
  a_record_we: assert property (p_record_we) else $error("cr strobe missing");

  property p_cr_we_pairs;
    @(posedge clk) disable iff (!rst_n)
      condFieldZeroWe |-> destWe;
  endproperty
  a_cr_we_pairs: assert property (p_cr_we_pairs) else $error("cr strobe alone");

  property p_record_gt;
    @(posedge clk) disable iff (!rst_n)
      s_take_record |=> condFieldZeroOut[rmu_pkg::CR_GT]
        == (!destRegOut[WIDTH-1] && (destRegOut != '0));
  endproperty
  a_record_gt: assert property (p_record_gt) else $error("cr gt wrong");

  property p_record_onehot;
    @(posedge clk) disable iff (!rst_n)
      condFieldZeroWe |-> $onehot(condFieldZeroOut[rmu_pkg::CR_LT:rmu_pkg::CR_EQ]);
  endproperty
  a_record_onehot: assert property (p_record_onehot) else $error("cr flags clash");
endmodule
